// *** core/crdf_framer.sv ***
`timescale 1ns/100ps
module crdf_framer import crdf_pkg::*; #(
    parameter int DATA_W = 512,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    // request from the link side
    input wire logic req_valid,
    output logic req_ready,
    input wire crdf_req_t req_in,
    // completer request stream
    output logic [DATA_W-1:0] cq_tdata,
    output logic [DATA_W/32-1:0] cq_tkeep,
    output logic cq_tlast,
    output logic cq_tvalid,
    input wire logic cq_tready,
    output logic [3:0] first_dword_byte_enables,
    output logic cq_is_sop,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);

    // descriptor must fit in the first beat; refused at elaboration, not at run time
    if (DATA_W < CRDF_DESC_W || DATA_W % 32 != 0 || ADDR_W < 8 || ADDR_W > 32) begin : g_bad_params
        $error("crdf_framer: unsupported DATA_W or ADDR_W");
    end

    localparam int KEEP_W = DATA_W / 32;
    localparam logic [KEEP_W-1:0] DESC_KEEP = KEEP_W'((1 << CRDF_DESC_DWORDS) - 1);

    function automatic logic is_bar_checked(input logic [3:0] t);
        is_bar_checked = (t <= CRDF_CAS);
    endfunction

    function automatic logic is_io(input logic [3:0] t);
        is_io = (t == CRDF_IO_RD) || (t == CRDF_IO_WR);
    endfunction

    function automatic logic is_mem(input logic [3:0] t);
        is_mem = (t == CRDF_MEM_RD) || (t == CRDF_MEM_WR);
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        // widened compare, so upper address bits must be zero and ADDR_W of 8 needs no empty slice
        reg_hit = (a == ADDR_W'(off));
    endfunction

    // control and status state
    logic ari_en_q, ari_en_d;
    logic root_port_q, root_port_d;
    logic [31:0] pkt_count_q, pkt_count_d;
    logic size_err_q, size_err_d;

    // stream output state
    logic out_valid_q, out_valid_d;
    logic [CRDF_DESC_W-1:0] desc_q, desc_d;
    logic [3:0] fbe_q, fbe_d;
    logic req_ready_q, req_ready_d;

    // bus state
    logic aw_hold_q, aw_hold_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic w_hold_q, w_hold_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // descriptor assembly, from the accepted request and the ARI and root port control bits
    logic [CRDF_DESC_W-1:0] desc_new;
    logic [3:0] fbe_new;
    logic [10:0] dw_new;
    logic [2:0] bar_new;
    logic size_bad;
    always_comb begin
        // R17: unused fields zero
        desc_new = '0;
        fbe_new = req_in.zero_len ? 4'h0 : 4'hf;
        size_bad = req_in.dword_count > CRDF_MAX_DW;
        // R1: size clamped to legal range
        dw_new = size_bad ? CRDF_MAX_DW : req_in.dword_count;
        if (is_io(req_in.req_type)) begin
            // R2: I/O is one dword
            dw_new = CRDF_ONE_DW;
        end else if (is_mem(req_in.req_type) && req_in.zero_len) begin
            // R3: zero-length one dword
            dw_new = CRDF_ONE_DW;
            fbe_new = 4'h0;
        end
        if (!is_mem(req_in.req_type) && !is_io(req_in.req_type)) begin
            fbe_new = req_in.zero_len ? 4'h0 : 4'hf;
        end
        desc_new[CRDF_DW_HI:CRDF_DW_LO] = dw_new;
        // R4: type code field
        // R5: codes pass as encoded
        desc_new[CRDF_TYPE_HI:CRDF_TYPE_LO] = req_in.req_type;
        // R6: requester id field
        // R7: ARI split is bitwise identical
        desc_new[CRDF_RID_HI:CRDF_RID_LO] = req_in.requester_id;
        // R8: echoed by user logic
        // R9: tag field
        desc_new[CRDF_TAG_HI:CRDF_TAG_LO] = req_in.tag;
        // R13: lower BAR of pair
        bar_new = req_in.bar_is_64 ? {req_in.bar_id[2:1], 1'b0} : req_in.bar_id;
        if (bar_new == CRDF_BAR_ROM) begin
            bar_new = CRDF_BAR_ROM; // rom is never part of a pair
        end
        // R12: root port BAR zero
        if (root_port_q) begin
            bar_new = CRDF_BAR_ZERO;
        end
        if (is_bar_checked(req_in.req_type)) begin
            // R10: function width by ARI
            desc_new[CRDF_FN_HI:CRDF_FN_LO] = ari_en_q ? req_in.target_fn
                                                        : (req_in.target_fn & CRDF_LEGACY_FN_MASK);
            // R11: BAR code field
            desc_new[CRDF_BAR_HI:CRDF_BAR_LO] = bar_new;
            // R14: aperture field
            // R15: per-VF aperture
            desc_new[CRDF_AP_HI:CRDF_AP_LO] = req_in.is_vf ? req_in.vf_aperture : req_in.bar_aperture;
        end
    end

    // stream next state; ready is registered so input never sees a combinational path
    logic take_req;
    logic beat_done;
    always_comb begin
        take_req = req_valid && req_ready_q;
        beat_done = out_valid_q && cq_tready;
        out_valid_d = out_valid_q;
        desc_d = desc_q;
        fbe_d = fbe_q;
        if (beat_done) begin
            out_valid_d = 1'b0;
        end
        if (take_req) begin
            out_valid_d = 1'b1;
            desc_d = desc_new;
            fbe_d = fbe_new;
        end
        req_ready_d = !out_valid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_q <= 1'b0;
            desc_q <= '0;
            fbe_q <= 4'h0;
            req_ready_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            desc_q <= desc_d;
            fbe_q <= fbe_d;
            req_ready_q <= req_ready_d;
        end
    end

    // R16: descriptor in first 16 bytes
    assign cq_tdata = {{(DATA_W-CRDF_DESC_W){1'b0}}, desc_q};
    assign cq_tkeep = DESC_KEEP;
    assign cq_tlast = out_valid_q; // payload lies outside this block, one beat per packet
    assign cq_is_sop = out_valid_q;
    assign cq_tvalid = out_valid_q;
    assign first_dword_byte_enables = fbe_q;
    assign req_ready = req_ready_q;

    // bus write path: address and data may arrive in either order
    logic do_write;
    always_comb begin
        aw_hold_d = aw_hold_q;
        awaddr_d = awaddr_q;
        w_hold_d = w_hold_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ari_en_d = ari_en_q;
        root_port_d = root_port_q;
        do_write = aw_hold_q && w_hold_q && !bvalid_q;
        if (s_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_awaddr;
        end
        if (s_wvalid && wready_q) begin
            w_hold_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        if (bvalid_q && s_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = CRDF_RESP_OKAY;
            if (reg_hit(awaddr_q, CRDF_CTRL_OFF)) begin
                if (wstrb_q[0]) begin
                    ari_en_d = wdata_q[CRDF_CTRL_ARI_BIT];
                    root_port_d = wdata_q[CRDF_CTRL_RP_BIT];
                end
            end else if (!reg_hit(awaddr_q, CRDF_ERR_OFF) && !reg_hit(awaddr_q, CRDF_COUNT_OFF)) begin
                bresp_d = CRDF_RESP_SLVERR;
            end
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d = !w_hold_d && !bvalid_d;
    end

    // counters and sticky error; a new size error wins over a clear in the same cycle
    always_comb begin
        pkt_count_d = beat_done ? pkt_count_q + 32'h1 : pkt_count_q;
        size_err_d = size_err_q;
        if (do_write && reg_hit(awaddr_q, CRDF_ERR_OFF) && wstrb_q[0] && wdata_q[CRDF_ERR_SIZE_BIT]) begin
            size_err_d = 1'b0;
        end
        if (take_req && size_bad) begin
            size_err_d = 1'b1;
        end
    end

    // bus read path: one outstanding read, answered the cycle after the address is taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = CRDF_RESP_OKAY;
            rdata_d = 32'h0;
            if (reg_hit(s_araddr, CRDF_CTRL_OFF)) begin
                rdata_d[CRDF_CTRL_ARI_BIT] = ari_en_q;
                rdata_d[CRDF_CTRL_RP_BIT] = root_port_q;
            end else if (reg_hit(s_araddr, CRDF_COUNT_OFF)) begin
                rdata_d = pkt_count_q;
            end else if (reg_hit(s_araddr, CRDF_ERR_OFF)) begin
                rdata_d[CRDF_ERR_SIZE_BIT] = size_err_q;
            end else begin
                rresp_d = CRDF_RESP_SLVERR;
            end
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
            w_hold_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            ari_en_q <= CRDF_CTRL_RST[CRDF_CTRL_ARI_BIT];
            root_port_q <= CRDF_CTRL_RST[CRDF_CTRL_RP_BIT];
            pkt_count_q <= 32'h0;
            size_err_q <= 1'b0;
        end else begin
            aw_hold_q <= aw_hold_d;
            awaddr_q <= awaddr_d;
            w_hold_q <= w_hold_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ari_en_q <= ari_en_d;
            root_port_q <= root_port_d;
            pkt_count_q <= pkt_count_d;
            size_err_q <= size_err_d;
        end
    end

    assign s_awready = awready_q;
    assign s_wready = wready_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_arready = arready_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;

endmodule

// *** core/crdf_pkg.sv ***
// Behaviour
// R1: size in dwords at bits 74:64, 0..256
// R2: I/O requests always report one dword
// R3: zero-length memory: one dword, byte enables zero
// R4: request type code at bits 78:75
// R5: type codes for memory, I/O, atomic, messages
// R6: requester id at 95:80, bus/device/function
// R7: ARI: bus 95:88, function 87:80
// R8: user returns requester id and tag unchanged
// R9: tag at bits 103:96
// R10: target function at 111:104, ARI-dependent width
// R11: matching BAR code at 114:112, ROM 110
// R12: root port always reports BAR zero
// R13: 64-bit BAR pair reports lower BAR
// R14: BAR aperture log2 at bits 120:115
// R15: VF aperture covers one function only
// R16: descriptor is first 16 bytes, beat one
// R17: undefined fields are driven to zero
package crdf_pkg;
    // register byte offsets
    localparam logic [7:0] CRDF_CTRL_OFF = 8'h00;
    localparam logic [7:0] CRDF_COUNT_OFF = 8'h04;
    localparam logic [7:0] CRDF_ERR_OFF = 8'h08;
    // control fields and reset values
    localparam int CRDF_CTRL_ARI_BIT = 0;
    localparam int CRDF_CTRL_RP_BIT = 1;
    localparam logic [1:0] CRDF_CTRL_RST = 2'h0;
    localparam int CRDF_ERR_SIZE_BIT = 0;
    // descriptor field positions
    localparam int CRDF_DW_LO = 64;
    localparam int CRDF_DW_HI = 74;
    localparam int CRDF_TYPE_LO = 75;
    localparam int CRDF_TYPE_HI = 78;
    localparam int CRDF_RID_LO = 80;
    localparam int CRDF_RID_HI = 95;
    localparam int CRDF_TAG_LO = 96;
    localparam int CRDF_TAG_HI = 103;
    localparam int CRDF_FN_LO = 104;
    localparam int CRDF_FN_HI = 111;
    localparam int CRDF_BAR_LO = 112;
    localparam int CRDF_BAR_HI = 114;
    localparam int CRDF_AP_LO = 115;
    localparam int CRDF_AP_HI = 120;
    localparam int CRDF_DESC_W = 128;
    localparam int CRDF_DESC_DWORDS = 4;
    // sizes and codes
    localparam logic [10:0] CRDF_MAX_DW = 11'h100;
    localparam logic [10:0] CRDF_ONE_DW = 11'h001;
    localparam logic [2:0] CRDF_BAR_ROM = 3'h6;
    localparam logic [2:0] CRDF_BAR_ZERO = 3'h0;
    localparam logic [7:0] CRDF_LEGACY_FN_MASK = 8'h07;
    localparam logic [1:0] CRDF_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRDF_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        CRDF_MEM_RD = 4'b0000,
        CRDF_MEM_WR = 4'b0001,
        CRDF_IO_RD = 4'b0010,
        CRDF_IO_WR = 4'b0011,
        CRDF_FETCH_ADD = 4'b0100,
        CRDF_SWAP = 4'b0101,
        CRDF_CAS = 4'b0110,
        CRDF_MSG = 4'b1100,
        CRDF_MSG_VDM = 4'b1101,
        CRDF_MSG_ATS = 4'b1110
    } crdf_type_t;

    // one received request as decoded from the link side
    typedef struct packed {
        logic [3:0] req_type;
        logic [10:0] dword_count;
        logic zero_len;
        logic [15:0] requester_id;
        logic [7:0] tag;
        logic [7:0] target_fn;
        logic [2:0] bar_id;
        logic bar_is_64;
        logic is_vf;
        logic [5:0] bar_aperture;
        logic [5:0] vf_aperture;
    } crdf_req_t;
endpackage

// *** verif/crdf_framer_props.sv ***
`timescale 1ns/100ps
module crdf_framer_props import crdf_pkg::*; #(
    parameter int DATA_W = 512
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire crdf_req_t req_in,
    input wire logic [DATA_W-1:0] cq_tdata,
    input wire logic cq_tlast,
    input wire logic cq_tvalid,
    input wire logic cq_tready,
    input wire logic [3:0] first_dword_byte_enables
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // request taken from the link side
    sequence s_take;
        req_valid && req_ready;
    endsequence
    // request that carries bar fields
    sequence s_take_bar;
        s_take ##0 (req_in.req_type < 4'h7);
    endsequence
    AST_BEAT_NEXT: assert property (s_take |=> cq_tvalid && cq_tlast)
        else $error("no single beat after request");
    AST_BEAT_HOLD: assert property (cq_tvalid && !cq_tready |=> cq_tvalid && $stable(cq_tdata))
        else $error("stalled beat changed");
    AST_TYPE_ID_TAG: assert property (s_take |=> cq_tdata[103:75] ==
        {$past(req_in.tag), $past(req_in.requester_id), 1'b0, $past(req_in.req_type)})
        else $error("type, id or tag wrong");
    AST_IO_ONE: assert property (cq_tvalid && cq_tdata[78:76] == 3'h1 |-> cq_tdata[74:64] == 11'h001)
        else $error("io size not one");
    AST_SIZE_MAX: assert property (cq_tvalid |-> cq_tdata[74:64] <= 11'h100)
        else $error("size above limit");
    AST_ZERO_LEN: assert property ((s_take ##0 (req_in.zero_len && req_in.req_type < 4'h2))
        |=> cq_tdata[74:64] == 11'h001 && first_dword_byte_enables == 4'h0)
        else $error("zero length not one dword");
    AST_BAR_PAIR: assert property ((s_take_bar ##0 req_in.bar_is_64) |=> !cq_tdata[112])
        else $error("bar pair not lower");
    AST_APERTURE: assert property (s_take_bar |=> cq_tdata[120:115] ==
        ($past(req_in.is_vf) ? $past(req_in.vf_aperture) : $past(req_in.bar_aperture)))
        else $error("aperture wrong");
    AST_NO_BAR_FIELDS: assert property (cq_tvalid && cq_tdata[78:75] > 4'h6 |-> cq_tdata[120:104] == '0)
        else $error("bar fields set for message");
    AST_UPPER_ZERO: assert property (cq_tvalid |-> cq_tdata[DATA_W-1:121] == '0)
        else $error("bits above descriptor set");
endmodule
bind crdf_framer crdf_framer_props #(.DATA_W(DATA_W)) props_u (.aclk(aclk), .aresetn(aresetn),
    .req_valid(req_valid), .req_ready(req_ready), .req_in(req_in), .cq_tdata(cq_tdata),
    .cq_tlast(cq_tlast), .cq_tvalid(cq_tvalid), .cq_tready(cq_tready),
    .first_dword_byte_enables(first_dword_byte_enables));

// *** verif/crdf_framer_tb_top.sv ***
`timescale 1ns/100ps
module crdf_framer_tb_top import crdf_pkg::*;;
    logic aclk, aresetn, req_valid, req_ready, stall, ari, rp;
    logic cq_tlast, cq_tvalid, cq_tready, cq_is_sop;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0] s_wstrb, fbe;
    logic [1:0] s_bresp, s_rresp, rs;
    logic [511:0] cq_tdata;
    logic [15:0] cq_tkeep;
    logic [23:0] echo;
    crdf_req_t req_in, r;
    int failures, n_compared, n_sent;
    crdf_framer dut_u (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req_ready(req_ready),
        .req_in(req_in), .cq_tdata(cq_tdata), .cq_tkeep(cq_tkeep), .cq_tlast(cq_tlast),
        .cq_tvalid(cq_tvalid), .cq_tready(cq_tready), .first_dword_byte_enables(fbe),
        .cq_is_sop(cq_is_sop), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready));
    crdf_user_model user_u (.aclk(aclk), .aresetn(aresetn), .stall(stall), .cq_tvalid(cq_tvalid),
        .cq_tdata(cq_tdata[127:0]), .cq_tready(cq_tready), .echo_q(echo));
    // one comparison, counted
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // write: aw and w offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_awready) begin
                aw = 1'b0;
                s_awvalid <= 1'b0;
            end
            if (w && s_wready) begin
                w = 1'b0;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        // bready stays high; lowering it here would clash with the next call in the same step
        resp = s_bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (s_rvalid !== 1'b1);
        d = s_rdata;
        // rready stays high for the same reason as bready
        resp = s_rresp;
    endtask
    function automatic logic [131:0] expd(input crdf_req_t q);
        logic [127:0] d;
        d = '0;
        d[74:64] = (q.dword_count > CRDF_MAX_DW) ? CRDF_MAX_DW : q.dword_count;
        if (q.req_type inside {4'h2, 4'h3} || (q.zero_len && q.req_type < 4'h2))
            d[74:64] = CRDF_ONE_DW;
        d[103:75] = {q.tag, q.requester_id, 1'b0, q.req_type};
        if (q.req_type < 4'h7) begin
            d[111:104] = ari ? q.target_fn : q.target_fn & 8'h07;
            d[114:112] = rp ? 3'h0 : q.bar_id & {2'h3, !q.bar_is_64};
            d[120:115] = q.is_vf ? q.vf_aperture : q.bar_aperture;
        end
        return {q.zero_len ? 4'h0 : 4'hf, d};
    endfunction
    // one request in, its single beat judged, echo of non-posted checked
    task automatic send(input crdf_req_t q);
        req_in <= q;
        req_valid <= 1'b1;
        do @(posedge aclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge aclk); while ({cq_tvalid, cq_tready} !== 2'h3);
        n_sent++;
        chk({fbe, cq_tdata[127:0]} === expd(q), "descriptor fields");
        chk(cq_tdata[511:128] === '0 && {cq_tlast, cq_is_sop, cq_tkeep} === 18'h3000f, "framing");
        // echo is registered at the handshake edge, visible from the next rising edge
        @(posedge aclk);
        if (q.req_type inside {4'h0, [4'h2:4'h6]})
            chk(echo === {q.tag, q.requester_id}, "echoed id and tag");
    endtask
    task automatic t_regs();
        axr(CRDF_CTRL_OFF, rd, rs);
        chk(rd === 32'h0 && rs === CRDF_RESP_OKAY, "ctrl reset");
        axw(CRDF_CTRL_OFF, 32'h3, rs);
        chk(rs === CRDF_RESP_OKAY, "ctrl write response");
        axr(CRDF_CTRL_OFF, rd, rs);
        chk(rd === 32'h3, "ctrl readback");
        axw(8'h0c, 32'h1, rs);
        chk(rs === CRDF_RESP_SLVERR, "unmapped write");
        axr(8'h0c, rd, rs);
        chk(rd === 32'h0 && rs === CRDF_RESP_SLVERR, "unmapped read");
        axw(CRDF_CTRL_OFF, 32'h0, rs);
    endtask
    // every type code, sink stalling
    task automatic t_types();
        logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hd, 4'he};
        stall <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            r = '{req_type: codes[i], dword_count: 11'h005 + 11'(i), zero_len: 1'b0,
                requester_id: 16'h1234 + 16'(i), tag: 8'h40 + 8'(i), target_fn: 8'hab,
                bar_id: 3'h3, bar_is_64: 1'b0, is_vf: 1'b0, bar_aperture: 6'h0c, vf_aperture: 6'h05};
            send(r);
        end
        stall <= 1'b0;
    endtask
    task automatic t_modes();
        r.req_type = 4'h0;
        r.bar_id = 3'h5;
        {ari, rp} = 2'h2;
        axw(CRDF_CTRL_OFF, 32'h1, rs);
        send(r);
        {ari, rp} = 2'h3;
        axw(CRDF_CTRL_OFF, 32'h3, rs);
        send(r);
        {ari, rp} = 2'h0;
        axw(CRDF_CTRL_OFF, 32'h0, rs);
        r.bar_is_64 = 1'b1;
        r.is_vf = 1'b1;
        send(r);
        r.bar_id = CRDF_BAR_ROM;
        r.bar_is_64 = 1'b0;
        send(r);
    endtask
    task automatic t_size();
        r.req_type = 4'h1;
        r.zero_len = 1'b1;
        r.dword_count = 11'h000;
        send(r);
        r.zero_len = 1'b0;
        r.dword_count = CRDF_MAX_DW;
        send(r);
        r.req_type = 4'hc;
        r.dword_count = 11'h000;
        send(r);
        r.dword_count = 11'h12c;
        send(r);
        axr(CRDF_ERR_OFF, rd, rs);
        chk(rd[0] === 1'b1, "size error flagged");
        axw(CRDF_ERR_OFF, 32'h1, rs);
        axr(CRDF_ERR_OFF, rd, rs);
        chk(rd[0] === 1'b0, "size error cleared");
        axr(CRDF_COUNT_OFF, rd, rs);
        chk(rd === 32'(n_sent), "packet count");
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        {aresetn, req_valid, stall, ari, rp, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata, req_in} = '0;
        s_wstrb = 4'hf;
        {failures, n_compared, n_sent} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_types();
        t_modes();
        t_size();
        conclude();
    end
endmodule

// *** verif/crdf_user_model.sv ***
`timescale 1ns/100ps
module crdf_user_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic cq_tvalid,
    input wire logic [127:0] cq_tdata,
    output logic cq_tready,
    output logic [23:0] echo_q
);
    logic [1:0] cnt_q;
    // slow sink takes one beat in three
    assign cq_tready = !stall || cnt_q == 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 2'h0;
            echo_q <= '0;
        end else begin
            cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
            if (cq_tvalid && cq_tready && cq_tdata[78:75] inside {4'h0, [4'h2:4'h6]})
                echo_q <= cq_tdata[103:80];
        end
    end
endmodule
